// ==== bench/tcrs_src_model.sv ====
// Far-side model: reference tick sources and film follower signals.
// Assumes clk_i is the block clock; every output changes just after a rising edge.
`timescale 1ns/10ps
module tcrs_src_model (
    input wire clk_i,
    input wire [1:0] vid_on_i,
    output reg xtal_o,
    output reg vid_a_o,
    output reg vid_b_o,
    output reg aux_o,
    output reg pwr_o,
    output reg rdr_o,
    output reg bip_o,
    output reg tach_o,
    output reg dir_o
);
    reg [15:0] cnt_q = 16'h0000;
    // ==========================================================
    // Sources
    initial {xtal_o, vid_a_o, vid_b_o, aux_o, pwr_o, rdr_o, bip_o, tach_o, dir_o} = 9'h000;
    // Reference ticks use co-prime periods 3, 5, 7, 11, 13; the two video lines share period 5 at different phases
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 16'h0001;
        xtal_o <= (cnt_q % 3) == 0;
        vid_a_o <= vid_on_i[0] && (cnt_q % 5) == 1; // Video absent: line idles low
        vid_b_o <= vid_on_i[1] && (cnt_q % 5) == 3;
        aux_o <= (cnt_q % 7) == 2;
        pwr_o <= (cnt_q % 11) == 4;
        rdr_o <= (cnt_q % 13) == 6;
        bip_o <= cnt_q[1];
        tach_o <= cnt_q[2:0] == 3'h5;
        dir_o <= cnt_q[5];
    end
endmodule

// ==== bench/tcrs_top_asserts.sv ====
// Checker for the reference and format selector, bound to its top module.
// Assumes one clock domain and the design header on the include path.
`timescale 1ns/10ps
`include "tcrs_defines.vh"
module tcrs_top_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`TCRS_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire gen_running_i,
    input wire film_biphase_i,
    input wire film_tach_i,
    input wire film_pulse_o,
    input wire xtal_tick_i,
    input wire external_video_input_a_i,
    input wire gen_ref_tick_o,
    input wire [1:0] film_rate_o,
    input wire [2:0] rate_led_o,
    input wire led_int_o,
    input wire led_vid_o,
    input wire led_aux_o,
    input wire led_pwr_o,
    input wire led_rdr_o,
    input wire gen_ref_err_o
);
    reg [7:0] ctl_q;
    // ==========================================================
    // Control shadow
    // Copied at the taken edge, so selections are judged without the body
    always @(posedge clk_i) begin
        if (rst_i)
            ctl_q <= 8'h00;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `TCRS_OFF_CTRL)
            ctl_q <= wb_dat_i[7:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_int_tick;
        xtal_tick_i && gen_running_i && ctl_q[7:5] == `TCRS_REF_INT
        ##1 gen_running_i && ctl_q[7:5] == `TCRS_REF_INT;
    endsequence
    // ==========================================================
    // Properties
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_film_follow: assert property (!$past(rst_i) |-> film_pulse_o ==
        ($past(ctl_q[0]) ? $past(film_tach_i) : $past(film_biphase_i)))
        else $error("film pulse from wrong input");
    chk_rate_leds: assert property (film_rate_o != 2'h3 |->
        rate_led_o == (3'h1 << film_rate_o)) else $error("rate indicator wrong");
    chk_int_tick: assert property (s_int_tick |=> gen_ref_tick_o)
        else $error("crystal tick not passed on");
    chk_single_led: assert property ($onehot0({led_int_o, led_vid_o, led_aux_o,
        led_pwr_o, led_rdr_o})) else $error("more than one source lit");
    chk_idle_dark: assert property (!$past(gen_running_i) && !$past(rst_i) |->
        !(led_int_o || led_aux_o || led_pwr_o || led_rdr_o)) else $error("lit while idle");
    chk_err_source: assert property (gen_ref_err_o |->
        $past(ctl_q[7:5]) == `TCRS_REF_VID || $past(ctl_q[7:5], 2) == `TCRS_REF_VID)
        else $error("reference error without video source");
    chk_vid_clears: assert property (external_video_input_a_i &&
        ctl_q[7:5] == `TCRS_REF_VID |-> ##[1:3] !gen_ref_err_o)
        else $error("error stays with video present");
endmodule

// ==== bench/test_timecode_ref_and_format_select.sv ====
// Self-checking bench for the reference and format selector.
// Assumes the source model and checker are compiled first.
`timescale 1ns/10ps
`include "tcrs_defines.vh"
module test_timecode_ref_and_format_select;
    localparam [14:0] ROLES = 15'b100_110_111_000_000;
    localparam [9:0] EXPS = 10'b01_10_00_11_01;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, gen_running_i = 1'b0;
    reg is_master_i = 1'b0, in_controller_i = 1'b0, is_ref_transport_i = 1'b0;
    reg ntsc_ref_i = 1'b0;
    reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    reg [31:0] wb_dat_i = 32'h0, rd;
    reg [1:0] gen_code_type_i = 2'h1, master_code_type_i = 2'h3, vid_on = 2'h2;
    reg [1:0] ctrl_ref_code_type_i = 2'h0, ref_transport_code_type_i = 2'h2;
    reg [4:0] src_v = 5'h0;
    wire [31:0] wb_dat_o;
    wire [2:0] rate_led_o;
    wire [1:0] reader_code_type_o, film_rate_o;
    wire wb_ack_o, irq_o, film_pulse_o, film_dir_o, reader_film_rate_o, gen_ref_tick_o;
    wire biphase_tick_o, led_int_o, led_vid_o, led_aux_o, led_pwr_o, led_rdr_o;
    wire gen_ref_err_o, film_biphase_i, film_tach_i, film_dir_i, xtal_tick_i;
    wire external_video_input_a_i, external_video_input_b_i, aux_tick_i;
    wire power_line_tick_i, timecode_input_tick_i;
    integer error_cnt = 0, samples_checked = 0, cyc_cnt = 0, i, m, n_in, n_out, n_bp;

    // Short flash and timeout keep the run in the thousands of cycles
    tcrs_top #(.FLASH_CYC(4), .VID_TMO(16)) dut (.*);
    tcrs_src_model src (.clk_i(clk_i), .vid_on_i(vid_on), .xtal_o(xtal_tick_i),
        .vid_a_o(external_video_input_a_i), .vid_b_o(external_video_input_b_i),
        .aux_o(aux_tick_i), .pwr_o(power_line_tick_i), .rdr_o(timecode_input_tick_i),
        .bip_o(film_biphase_i), .tach_o(film_tach_i), .dir_o(film_dir_i));

    // ==========================================================
    // Clock and watchdog
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end

    // ==========================================================
    // Tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Hold the request until ack is sampled at a rising edge, release at that edge
    task wb_xfer(input we, input [3:0] adr, input [31:0] dat);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= adr;
            wb_dat_i <= dat;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) @(posedge clk_i);
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    // Source ticks in a window against outputs two cycles later
    task count(input integer n);
        integer k;
        begin
            n_in = 0;
            n_out = 0;
            n_bp = 0;
            for (k = 0; k < n + 2; k = k + 1) begin
                @(negedge clk_i);
                if (k < n) n_in = n_in + (|(src_v & {timecode_input_tick_i,
                    power_line_tick_i, aux_tick_i,
                    external_video_input_a_i | external_video_input_b_i, xtal_tick_i}));
                if (k >= 2) n_out = n_out + gen_ref_tick_o;
                if (k >= 2) n_bp = n_bp + biphase_tick_o;
            end
        end
    endtask
    task conclude;
        begin
            $display("Checked %0d, mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(0, `TCRS_OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        check(rate_led_o, 3'h1);
        for (i = 0; i < 3; i = i + 1) begin
            wb_xfer(1, `TCRS_OFF_CTRL, i << 3);
            repeat (2) @(negedge clk_i);
            check(rate_led_o, 3'h1 << i);
            check(reader_code_type_o, i);
            check(reader_film_rate_o, 1'b1);
            wb_xfer(0, `TCRS_OFF_STAT, 32'h0);
            check(rd[3:0], {i[1:0], i[1:0]});
        end
        $display("Rates done");
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clk_i);
            {is_master_i, in_controller_i, is_ref_transport_i} <= ROLES[3*i +: 3];
            wb_xfer(1, `TCRS_OFF_CTRL, (i == 0) ? 32'h2 : 32'h4);
            repeat (2) @(negedge clk_i);
            check(reader_code_type_o, EXPS[2*i +: 2]);
            check(reader_film_rate_o, 1'b0);
        end
        $display("Formats done");
        for (m = 0; m < 2; m = m + 1) begin
            wb_xfer(1, `TCRS_OFF_CTRL, m);
            repeat (20) begin
                @(negedge clk_i);
                i = m ? {film_tach_i, film_dir_i} : {film_biphase_i, 1'b1};
                @(negedge clk_i);
                check({film_pulse_o, film_dir_o}, i);
            end
        end
        $display("Film input done");
        @(posedge clk_i);
        gen_running_i <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            wb_xfer(1, `TCRS_OFF_CTRL, i << 5);
            src_v = 5'h1 << i;
            count(130);
            check(n_out, n_in);
            check(n_bp, n_in);
            check({led_rdr_o, led_pwr_o, led_aux_o, led_vid_o, led_int_o}, src_v);
        end
        @(posedge clk_i);
        gen_running_i <= 1'b0;
        count(40);
        check(n_out, 0);
        check({led_rdr_o, led_pwr_o, led_aux_o, led_vid_o, led_int_o}, 5'h0);
        $display("Sources done");
        @(posedge clk_i);
        vid_on <= 2'h0;
        wb_xfer(1, `TCRS_OFF_IRQ_MASK, 32'h1);
        wb_xfer(1, `TCRS_OFF_CTRL, 32'h20);
        repeat (40) @(negedge clk_i);
        check(gen_ref_err_o, 1'b1);
        check(irq_o, 1'b1);
        wb_xfer(0, `TCRS_OFF_STAT, 32'h0);
        check(rd[5:4], 2'h2);
        n_in = 0;
        repeat (16) begin
            @(negedge clk_i);
            n_in = n_in + led_vid_o;
        end
        check(n_in, 8);
        wb_xfer(1, `TCRS_OFF_IRQ_STAT, 32'h7);
        wb_xfer(0, `TCRS_OFF_IRQ_STAT, 32'h0);
        check(rd, 32'h0);
        check(irq_o, 1'b0);
        wb_xfer(0, 4'h2, 32'h0);
        check(rd, 32'h0);
        // A write without the low byte lane must leave the selection alone
        wb_sel_i <= 4'he;
        wb_xfer(1, `TCRS_OFF_CTRL, 32'h40);
        wb_sel_i <= 4'hf;
        wb_xfer(0, `TCRS_OFF_CTRL, 32'h0);
        check(rd, 32'h20);
        @(posedge clk_i);
        vid_on <= 2'h1;
        repeat (10) @(negedge clk_i);
        check(gen_ref_err_o, 1'b0);
        check(led_vid_o, 1'b0);
        $display("Video loss done");
        @(posedge clk_i);
        ntsc_ref_i <= 1'b1;
        gen_running_i <= 1'b1;
        wb_xfer(1, `TCRS_OFF_CTRL, 32'h0);
        src_v = 5'h1;
        count(3000);
        check(n_out, n_in);
        check(n_bp, n_out - 1);
        $display("Pull-down done");
        conclude;
    end
endmodule

bind tcrs_top tcrs_top_asserts chk (.*);

// ==== common/tcrs_defines.vh ====
// Register map, field positions, reset values and timing counts for the
// time code reference and format select block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave.
`ifndef TCRS_DEFINES_VH
`define TCRS_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define TCRS_ADDR_W 4
`define TCRS_OFF_CTRL 4'h0
`define TCRS_OFF_STAT 4'h4
`define TCRS_OFF_IRQ_STAT 4'h8
`define TCRS_OFF_IRQ_MASK 4'hc

// ==========================================================================
// Control register fields
`define TCRS_CTRL_FILM_IN 0
`define TCRS_CTRL_FMT_LO 1
`define TCRS_CTRL_FMT_HI 2
`define TCRS_CTRL_RATE_LO 3
`define TCRS_CTRL_RATE_HI 4
`define TCRS_CTRL_REF_LO 5
`define TCRS_CTRL_REF_HI 7
`define TCRS_CTRL_W 8
`define TCRS_CTRL_RST 8'h00

// Reader format codes
`define TCRS_FMT_FILM 2'h0
`define TCRS_FMT_GEN 2'h1
`define TCRS_FMT_SYSTEM 2'h2

// Film frame rate codes
`define TCRS_RATE_24 2'h0
`define TCRS_RATE_25 2'h1
`define TCRS_RATE_30 2'h2

// Generator reference source codes
`define TCRS_REF_INT 3'h0
`define TCRS_REF_VID 3'h1
`define TCRS_REF_AUX 3'h2
`define TCRS_REF_PWR 3'h3
`define TCRS_REF_RDR 3'h4

// ==========================================================================
// Interrupt bits
`define TCRS_IRQ_W 3
`define TCRS_IRQ_VID_LOST 0
`define TCRS_IRQ_REF_CHG 1
`define TCRS_IRQ_FMT_CHG 2

// ==========================================================================
// Timing
`define TCRS_CLK_MHZ 250
`define TCRS_FLASH_MS 250
`define TCRS_FLASH_CYC (`TCRS_FLASH_MS * `TCRS_CLK_MHZ * 1000)
`define TCRS_VID_TMO_MS 100
`define TCRS_VID_TMO_CYC (`TCRS_VID_TMO_MS * `TCRS_CLK_MHZ * 1000)
// NTSC pull-down: drop one tick in every thousand
`define TCRS_NTSC_DIV 1000

`endif

// ==== core/tcrs_ref_mux.v ====
// Generator reference selector: picks one speed tick source and flags a
// missing video reference.
// Assumes every tick input is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/10ps
`include "tcrs_defines.vh"

module tcrs_ref_mux #(
    parameter VID_TMO = `TCRS_VID_TMO_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] ref_sel_i,
    input wire xtal_tick_i,
    input wire vid_a_tick_i,
    input wire vid_b_tick_i,
    input wire aux_tick_i,
    input wire pwr_tick_i,
    input wire rdr_tick_i,
    output reg ref_tick_o,
    output reg vid_present_o
);

    reg [31:0] vid_cnt_q;
    wire vid_tick;

    assign vid_tick = vid_a_tick_i | vid_b_tick_i;

    // =====================================================================
    // Video watchdog: presence drops after a silent timeout
    always @(posedge clk_i) begin
        if (rst_i) begin
            vid_cnt_q <= 32'h0;
            vid_present_o <= 1'b0;
        end else if (vid_tick) begin
            vid_cnt_q <= 32'h0;
            vid_present_o <= 1'b1;
        end else if (vid_cnt_q >= VID_TMO - 1) begin
            vid_present_o <= 1'b0;
        end else begin
            vid_cnt_q <= vid_cnt_q + 32'h1;
        end
    end

    // =====================================================================
    // One source only reaches the generator
    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_tick_o <= 1'b0;
        end else begin
            case (ref_sel_i)
                `TCRS_REF_INT: ref_tick_o <= xtal_tick_i;
                `TCRS_REF_VID: ref_tick_o <= vid_tick;
                `TCRS_REF_AUX: ref_tick_o <= aux_tick_i;
                `TCRS_REF_PWR: ref_tick_o <= pwr_tick_i;
                `TCRS_REF_RDR: ref_tick_o <= rdr_tick_i;
                default: ref_tick_o <= xtal_tick_i;
            endcase
        end
    end

endmodule

// ==== core/tcrs_top.v ====
// Time code reference and reader format selection with Wishbone registers.
// Assumes classic Wishbone single cycles and pulse inputs synchronous to clk_i.
`timescale 1ns/10ps
`include "tcrs_defines.vh"

// Function
// - Film input decodes biphase or tach/direction
// - Film format counts at film frame rate
// - Generator format copies generator code type
// - System slave follows master deck code type
// - System master reference uses controller type
// - Stand-alone master follows generator code type
// - Selected reference drives generator and system speed
// - Internal source uses crystal, lights its indicator
// - Video source locks to either video input
// - Missing video flashes indicator, posts error
// - Auxiliary source locks to 50-60 Hz input
// - Power line source uses AC power_line_tick_i
// - Reader source uses incoming time code
// - Frame rate 24/25/30 shown on indicators
// - NTSC reference slows biphase by 0.1%
module tcrs_top #(
    parameter FLASH_CYC = `TCRS_FLASH_CYC,
    parameter VID_TMO = `TCRS_VID_TMO_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`TCRS_ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg irq_o,
    input wire gen_running_i,
    input wire is_master_i,
    input wire in_controller_i,
    input wire is_ref_transport_i,
    input wire ntsc_ref_i,
    input wire [1:0] gen_code_type_i,
    input wire [1:0] master_code_type_i,
    input wire [1:0] ctrl_ref_code_type_i,
    input wire [1:0] ref_transport_code_type_i,
    input wire film_biphase_i,
    input wire film_tach_i,
    input wire film_dir_i,
    input wire xtal_tick_i,
    input wire external_video_input_a_i,
    input wire external_video_input_b_i,
    input wire aux_tick_i,
    input wire power_line_tick_i,
    input wire timecode_input_tick_i,
    output reg film_pulse_o,
    output reg film_dir_o,
    output reg [1:0] reader_code_type_o,
    output reg reader_film_rate_o,
    output reg [1:0] film_rate_o,
    output reg [2:0] rate_led_o,
    output reg gen_ref_tick_o,
    output reg biphase_tick_o,
    output reg led_int_o,
    output reg led_vid_o,
    output reg led_aux_o,
    output reg led_pwr_o,
    output reg led_rdr_o,
    output reg gen_ref_err_o
);

    // =====================================================================
    // Register state
    reg [`TCRS_CTRL_W-1:0] ctrl_q;
    reg [`TCRS_IRQ_W-1:0] irq_stat_q;
    reg [`TCRS_IRQ_W-1:0] irq_mask_q;
    reg [`TCRS_IRQ_W-1:0] irq_ev;
    reg [31:0] rd_d;
    reg [31:0] flash_cnt_q;
    reg flash_q;
    reg [9:0] ntsc_cnt_q;
    reg vid_present_q;
    reg [2:0] ref_prev_q;
    reg [1:0] fmt_prev_q;
    reg [1:0] code_d;
    wire film_in_tach;
    wire [1:0] fmt_sel;
    wire [1:0] rate_sel;
    wire [2:0] ref_sel;
    wire ref_tick;
    wire vid_present;
    wire wb_req;
    wire wr_ctrl;
    wire wr_stat;
    wire wr_mask;

    assign film_in_tach = ctrl_q[`TCRS_CTRL_FILM_IN];
    assign fmt_sel = ctrl_q[`TCRS_CTRL_FMT_HI:`TCRS_CTRL_FMT_LO];
    assign rate_sel = ctrl_q[`TCRS_CTRL_RATE_HI:`TCRS_CTRL_RATE_LO];
    assign ref_sel = ctrl_q[`TCRS_CTRL_REF_HI:`TCRS_CTRL_REF_LO];

    // Write one to clear mask from the low byte lane
    function [`TCRS_IRQ_W-1:0] clr_mask;
        input wr;
        input [3:0] sel;
        input [31:0] dat;
        begin
            clr_mask = (wr && sel[0]) ? dat[`TCRS_IRQ_W-1:0] : {`TCRS_IRQ_W{1'b0}};
        end
    endfunction

    // =====================================================================
    // Wishbone slave: one wait state, ack drops the cycle after it rises
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == `TCRS_OFF_CTRL) & wb_sel_i[0];
    assign wr_stat = wb_req & wb_we_i & (wb_adr_i == `TCRS_OFF_IRQ_STAT);
    assign wr_mask = wb_req & wb_we_i & (wb_adr_i == `TCRS_OFF_IRQ_MASK) & wb_sel_i[0];

    // Read mux; unmapped addresses read zero and still ack
    always @* begin
        rd_d = 32'h0;
        case (wb_adr_i)
            `TCRS_OFF_CTRL: rd_d[`TCRS_CTRL_W-1:0] = ctrl_q;
            `TCRS_OFF_STAT: rd_d[5:0] = {gen_ref_err_o, vid_present_q, reader_code_type_o,
                                         film_rate_o};
            `TCRS_OFF_IRQ_STAT: rd_d[`TCRS_IRQ_W-1:0] = irq_stat_q;
            `TCRS_OFF_IRQ_MASK: rd_d[`TCRS_IRQ_W-1:0] = irq_mask_q;
            default: rd_d = 32'h0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_d : 32'h0;
        end
    end

    // =====================================================================
    // Control register: film input, format, rate and reference select
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `TCRS_CTRL_RST; // Film format and internal ref by default
        end else if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[`TCRS_CTRL_W-1:0];
        end
    end

    // =====================================================================
    // Film follower input: biphase edges or tach with separate direction
    always @(posedge clk_i) begin
        if (rst_i) begin
            film_pulse_o <= 1'b0;
            film_dir_o <= 1'b0;
        end else if (film_in_tach) begin
            film_pulse_o <= film_tach_i;
            film_dir_o <= film_dir_i;
        end else begin
            film_pulse_o <= film_biphase_i;
            film_dir_o <= 1'b1; // Biphase carries no direction pin; assume forward
        end
    end

    // =====================================================================
    // Reader code type resolution
    always @* begin
        code_d = rate_sel;
        case (fmt_sel)
            `TCRS_FMT_FILM: code_d = rate_sel;
            `TCRS_FMT_GEN: code_d = gen_code_type_i;
            `TCRS_FMT_SYSTEM: begin
                if (!is_master_i) begin
                    code_d = master_code_type_i;
                end else if (in_controller_i) begin
                    if (is_ref_transport_i) begin
                        code_d = ctrl_ref_code_type_i;
                    end else begin
                        code_d = ref_transport_code_type_i;
                    end
                end else begin
                    code_d = gen_code_type_i;
                end
            end
            default: code_d = rate_sel;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            reader_code_type_o <= `TCRS_RATE_24;
            reader_film_rate_o <= 1'b1;
            film_rate_o <= `TCRS_RATE_24;
            rate_led_o <= 3'h1;
        end else begin
            reader_code_type_o <= code_d;
            reader_film_rate_o <= (fmt_sel == `TCRS_FMT_FILM);
            film_rate_o <= rate_sel;
            // One-hot frame rate indicators 24, 25, 30
            case (rate_sel)
                `TCRS_RATE_24: rate_led_o <= 3'h1;
                `TCRS_RATE_25: rate_led_o <= 3'h2;
                `TCRS_RATE_30: rate_led_o <= 3'h4;
                default: rate_led_o <= 3'h1;
            endcase
        end
    end

    // =====================================================================
    // Reference source mux and video watchdog
    tcrs_ref_mux #(
        .VID_TMO(VID_TMO)
    ) u_ref_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_sel_i(ref_sel),
        .xtal_tick_i(xtal_tick_i),
        .vid_a_tick_i(external_video_input_a_i),
        .vid_b_tick_i(external_video_input_b_i),
        .aux_tick_i(aux_tick_i),
        .pwr_tick_i(power_line_tick_i),
        .rdr_tick_i(timecode_input_tick_i),
        .ref_tick_o(ref_tick),
        .vid_present_o(vid_present)
    );

    // =====================================================================
    // Generator speed tick plus NTSC pull-down for the biphase generator
    always @(posedge clk_i) begin
        if (rst_i) begin
            gen_ref_tick_o <= 1'b0;
            biphase_tick_o <= 1'b0;
            ntsc_cnt_q <= 10'h0;
        end else begin
            gen_ref_tick_o <= ref_tick & gen_running_i;
            biphase_tick_o <= 1'b0;
            if (ref_tick && gen_running_i) begin
                if (ntsc_cnt_q == `TCRS_NTSC_DIV - 1) begin
                    ntsc_cnt_q <= 10'h0;
                    biphase_tick_o <= ~ntsc_ref_i; // Drop 1 in 1000 ticks
                end else begin
                    ntsc_cnt_q <= ntsc_cnt_q + 10'h1;
                    biphase_tick_o <= 1'b1;
                end
            end
        end
    end

    // =====================================================================
    // Flash divider for the video indicator; slow enable, single clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            flash_cnt_q <= 32'h0;
            flash_q <= 1'b0;
        end else if (flash_cnt_q >= FLASH_CYC - 1) begin
            flash_cnt_q <= 32'h0;
            flash_q <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    // =====================================================================
    // Source indicators; error flashes even when the generator is idle
    always @(posedge clk_i) begin
        if (rst_i) begin
            led_int_o <= 1'b0;
            led_vid_o <= 1'b0;
            led_aux_o <= 1'b0;
            led_pwr_o <= 1'b0;
            led_rdr_o <= 1'b0;
            gen_ref_err_o <= 1'b0;
            vid_present_q <= 1'b0;
        end else begin
            vid_present_q <= vid_present;
            gen_ref_err_o <= (ref_sel == `TCRS_REF_VID) & ~vid_present;
            led_int_o <= gen_running_i & (ref_sel == `TCRS_REF_INT);
            if (ref_sel == `TCRS_REF_VID && !vid_present) begin
                led_vid_o <= flash_q;
            end else begin
                led_vid_o <= gen_running_i & (ref_sel == `TCRS_REF_VID);
            end
            led_aux_o <= gen_running_i & (ref_sel == `TCRS_REF_AUX);
            led_pwr_o <= gen_running_i & (ref_sel == `TCRS_REF_PWR);
            led_rdr_o <= gen_running_i & (ref_sel == `TCRS_REF_RDR);
        end
    end

    // =====================================================================
    // Sticky interrupt status: set wins over a write-one clear
    always @* begin
        irq_ev = {`TCRS_IRQ_W{1'b0}};
        irq_ev[`TCRS_IRQ_VID_LOST] = vid_present_q & ~vid_present;
        irq_ev[`TCRS_IRQ_REF_CHG] = (ref_prev_q != ref_sel);
        irq_ev[`TCRS_IRQ_FMT_CHG] = (fmt_prev_q != code_d);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= {`TCRS_IRQ_W{1'b0}};
            irq_mask_q <= {`TCRS_IRQ_W{1'b0}};
            ref_prev_q <= `TCRS_REF_INT;
            fmt_prev_q <= `TCRS_RATE_24;
            irq_o <= 1'b0;
        end else begin
            ref_prev_q <= ref_sel;
            fmt_prev_q <= code_d;
            irq_stat_q <= (irq_stat_q & ~clr_mask(wr_stat, wb_sel_i, wb_dat_i)) | irq_ev;
            if (wr_mask) begin
                irq_mask_q <= wb_dat_i[`TCRS_IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule
